// ### design/css_defs.svh
// Offsets, field positions and reset values of the processor status block.
// Assumes inclusion by the status block only.
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

`define CSS_STATUS_OFFSET   12'h000
`define CSS_EVENT_OFFSET    12'h004
`define CSS_STATUS_ADDR_W   12

`define CSS_B_COP3          31
`define CSS_B_COP2          30
`define CSS_B_FLOAT         29
`define CSS_B_COP0          28
`define CSS_B_FLIP          25
`define CSS_B_BOOTVEC       22
`define CSS_B_TLBSHUT       21
`define CSS_B_PARERR        20
`define CSS_B_ISOMISS       19
`define CSS_B_PARZERO       18
`define CSS_B_SWAP          17
`define CSS_B_ISOLATE       16
`define CSS_IM_HI           15
`define CSS_IM_LO           8
`define CSS_B_KUO           5
`define CSS_B_IEO           4
`define CSS_B_KUP           3
`define CSS_B_IEP           2
`define CSS_B_KUC           1
`define CSS_B_IEC           0

// Writable bits; fixed-zero and hardware flags are excluded
`define CSS_WMASK           32'hf247ff3f
// Kernel mode, interrupts off, boot vectors after reset
`define CSS_RESET_VALUE     32'h00400002
`define CSS_USER_ADDR_MAX   32'h7fffffff

`endif

// ### design/css_pkg.sv
// Types shared by the processor status block.
// Assumes css_defs.svh sits beside it.
package css_pkg;

  typedef struct packed {
    logic        cop_valid;    // Coprocessor instruction issuing
    logic [1:0]  cop_num;      // Which coprocessor
    logic        data_valid;   // Load or store issuing
    logic [31:0] data_addr;    // Its data address
    logic        data_partial; // Narrower than a word
    logic        priv_instr;   // Privileged instruction issuing
  } css_access_t;

  typedef struct packed {
    logic        take_exc;     // Exception entry this cycle
    logic        ret_exc;      // Return-from-exception this cycle
    logic        tlb_multi;    // Two TLB entries matched
    logic        parity_err;   // Cache parity error seen
    logic        dcache_miss;  // Data cache miss
    logic [5:0]  irq_pins;     // External interrupt lines
    logic [1:0]  sw_irq;       // Software interrupt cause bits
  } css_event_t;

  typedef struct packed {
    logic        cop_fault;    // Unusable coprocessor
    logic        addr_fault;   // User address out of range
    logic        priv_fault;   // Privileged in user mode
    logic        irq_take;     // Interrupt exception request
    logic [7:0]  irq_active;   // Unmasked pending sources
    logic        big_endian;   // Effective byte order
    logic        boot_vectors; // Use boot segment entry points
    logic        parity_zero;  // Write zero parity, skip checks
    logic        no_ext_bus;   // Suppress external data cycles
    logic        inval_store;  // Partial store invalidates
    logic        swap_caches;  // Caches exchange roles
  } css_ctrl_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] hrdata;
    logic        hready;
    logic        wr_pend;
    logic [11:0] addr;
    logic        sel;
    css_ctrl_t   ctrl;
  } css_state_t;

endpackage : css_pkg

// ### design/css_status.sv
// Processor status register with kernel/interrupt-enable mode stack.
// Assumes one core clock, AHB-Lite register access, core pulses for events.
//
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "css_defs.svh"

module css_status
  import css_pkg::*;
#(
  parameter bit HAS_TLB        = 1'b1, // Zero for the TLB-less variant
  parameter bit RESET_BIG_END  = 1'b1  // Byte order strapped at reset
) (
  input  wire logic        clk,        // Core clock, 40 MHz
  input  wire logic        rst_n,      // Asynchronous reset, active low
  input  wire logic        hsel,       // AHB-Lite select
  input  wire logic [31:0] haddr,      // Address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic [2:0]  hsize,      // Transfer size
  input  wire logic [31:0] hwdata,     // Write data
  input  wire logic        hready,     // Bus ready in
  output logic      [31:0] hrdata,     // Read data
  output logic             hreadyout,  // Slave ready
  output logic             hresp,      // Always OKAY
  input  wire css_access_t acc,        // Issuing access from pipeline
  input  wire css_event_t  evt,        // Exception and cache events
  output css_ctrl_t        ctrl        // Registered control to core
);

  css_state_t st;
  css_state_t next_st;
  logic       rst_int_n;
  // Kept out of st: it resets on the raw pin, the rest on its output
  logic [1:0] rst_sync;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  function automatic logic user_mode(input logic [31:0] s);
    return ~s[`CSS_B_KUC];
  endfunction : user_mode

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] s;
    logic        um;
    logic [7:0]  pend;
    s    = st.status;
    um   = user_mode(st.status);
    pend = {evt.irq_pins, evt.sw_irq};
    next_st          = st;

    // Bus slave: zero wait states; write lands in the data phase
    next_st.hready = 1'b1;
    if (st.wr_pend && st.addr == `CSS_STATUS_OFFSET) begin
      s = (s & ~`CSS_WMASK) | (hwdata & `CSS_WMASK);
    end
    next_st.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_st.addr    = haddr[11:0];
      next_st.wr_pend = hwrite;
      if (!hwrite) begin
        case (haddr[11:0])
          `CSS_STATUS_OFFSET: next_st.hrdata = st.status;
          `CSS_EVENT_OFFSET:  next_st.hrdata = {24'h0, pend};
          default:            next_st.hrdata = 32'h0;
        endcase
      end
    end

    // Mode stack: exception wins over a return in the same cycle
    if (evt.take_exc) begin
      s[5:2] = s[3:0];
      s[`CSS_B_KUC] = 1'b1;
      s[`CSS_B_IEC] = 1'b0;
    end else if (evt.ret_exc) begin
      s[3:0] = s[5:2];
    end

    // Hardware flags; set beats any software write
    if (HAS_TLB && evt.tlb_multi) s[`CSS_B_TLBSHUT] = 1'b1;
    if (evt.parity_err && !st.status[`CSS_B_PARZERO]) begin
      s[`CSS_B_PARERR] = 1'b1;
    end
    if (evt.dcache_miss && st.status[`CSS_B_ISOLATE]) begin
      s[`CSS_B_ISOMISS] = 1'b1;
    end
    s[`CSS_B_TLBSHUT] = s[`CSS_B_TLBSHUT] | st.status[`CSS_B_TLBSHUT];
    next_st.status = s;

    // Core-facing controls, from present register value
    next_st.ctrl.cop_fault = acc.cop_valid && (
        (acc.cop_num == 2'd0 && um && !st.status[`CSS_B_COP0]) ||
        (acc.cop_num == 2'd1 && !st.status[`CSS_B_FLOAT])   ||
        (acc.cop_num == 2'd2 && !st.status[`CSS_B_COP2])    ||
        (acc.cop_num == 2'd3 && !st.status[`CSS_B_COP3]));
    next_st.ctrl.addr_fault = acc.data_valid && um &&
        (acc.data_addr > `CSS_USER_ADDR_MAX);
    next_st.ctrl.priv_fault = acc.priv_instr && um &&
        !st.status[`CSS_B_COP0];
    next_st.ctrl.irq_active = pend & st.status[`CSS_IM_HI:`CSS_IM_LO];
    next_st.ctrl.irq_take   = st.status[`CSS_B_IEC] &&
        (|(pend & st.status[`CSS_IM_HI:`CSS_IM_LO]));
    next_st.ctrl.big_endian = RESET_BIG_END ^
        (um && st.status[`CSS_B_FLIP]);
    next_st.ctrl.boot_vectors = st.status[`CSS_B_BOOTVEC];
    next_st.ctrl.parity_zero  = st.status[`CSS_B_PARZERO];
    next_st.ctrl.no_ext_bus   = st.status[`CSS_B_ISOLATE];
    next_st.ctrl.inval_store  = st.status[`CSS_B_ISOLATE] &&
        acc.data_valid && acc.data_partial;
    next_st.ctrl.swap_caches  = st.status[`CSS_B_SWAP];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st.status  <= `CSS_RESET_VALUE | (HAS_TLB ? 32'h0 : 32'h00200000);
      st.hrdata  <= 32'h0;
      st.hready  <= 1'b1;
      st.wr_pend <= 1'b0;
      st.addr    <= 12'h0;
      st.sel     <= 1'b0;
      st.ctrl    <= '0;
    end else begin
      st.status  <= next_st.status;
      st.hrdata  <= next_st.hrdata;
      st.hready  <= next_st.hready;
      st.wr_pend <= next_st.wr_pend;
      st.addr    <= next_st.addr;
      st.sel     <= next_st.sel;
      st.ctrl    <= next_st.ctrl;
    end
  end

  assign hrdata    = st.hrdata;
  assign hreadyout = st.hready;
  assign hresp     = 1'b0;
  assign ctrl      = st.ctrl;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  AST_PUSH_KERNEL: assert property (evt.take_exc |=>
    st.status[1:0] == 2'b10 && st.status[3:2] == $past(st.status[1:0]))
    else $error("push did not enter kernel with irq off");
  AST_POP: assert property (evt.ret_exc && !evt.take_exc |=>
    st.status[1:0] == $past(st.status[3:2]))
    else $error("pop did not restore current pair");
  AST_POP_OLD: assert property (evt.ret_exc && !evt.take_exc &&
    !st.wr_pend |=> st.status[5:4] == $past(st.status[5:4]))
    else $error("pop disturbed old pair");
  AST_TLB_STICKY: assert property (st.status[21] |=> st.status[21])
    else $error("tlb shutdown flag cleared");
  AST_ZERO_BITS: assert property ((st.status & 32'h0d800040) == 32'h0)
    else $error("fixed zero bit set");
  AST_IRQ_OFF: assert property (!st.status[0] |=> !ctrl.irq_take)
    else $error("interrupt taken while disabled");
  AST_FLOAT: assert property (acc.cop_valid && acc.cop_num == 2'd1 &&
    !st.status[29] |=> ctrl.cop_fault)
    else $error("float op allowed while unusable");
  AST_COP0_KERNEL: assert property (acc.cop_valid &&
    acc.cop_num == 2'd0 && st.status[1] |=> !ctrl.cop_fault)
    else $error("cop0 refused in kernel");
  AST_ISOMISS: assert property (evt.dcache_miss && st.status[16]
    |=> st.status[19])
    else $error("isolated miss not flagged");
  AST_ENDIAN: assert property (st.status[1] |=>
    ctrl.big_endian == RESET_BIG_END)
    else $error("kernel byte order changed");

  COV_PUSH_POP: cover property (evt.take_exc ##[1:20] evt.ret_exc);
  COV_NESTED: cover property (evt.take_exc ##1 evt.take_exc);
  COV_IRQ: cover property (ctrl.irq_take);
  COV_WRITE: cover property (st.wr_pend);

endmodule : css_status

// ### dv/css_core_model.sv
// Core-side partner: pipeline access levels and exception/cache events.
// Assumes the bench calls its tasks; drives on the rising clock edge.
`timescale 1ns/1ps

module css_core_model
  import css_pkg::*;
(
  input  wire logic clk, // Core clock
  output css_access_t acc, // Issuing access
  output css_event_t  evt  // Event pulses and irq levels
);
  initial begin
    acc = '0;
    evt = '0;
  end

  // Pulse bits only; irq levels in e must be zero
  task automatic pulse(input css_event_t e);
    @(posedge clk);
    evt <= evt | e;
    @(posedge clk);
    evt <= evt & ~e;
  endtask : pulse

  task automatic set_acc(input css_access_t a, input logic [7:0] pend);
    @(posedge clk);
    acc <= a;
    evt.irq_pins <= pend[7:2];
    evt.sw_irq   <= pend[1:0];
  endtask : set_acc
endmodule : css_core_model

// ### dv/tb.sv
// Self-checking bench of the status block: bus, control table, stack, flags.
// Assumes default parameters: TLB present, big-endian strap.
`timescale 1ns/1ps

module tb
  import css_pkg::*;
;
  typedef struct packed {
    logic [31:0] st;
    css_access_t a;
    logic [7:0]  pend;
  } css_row_t;

  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        hreadyout, hresp;
  css_access_t acc;
  css_event_t  evt;
  css_ctrl_t   ctrl;
  int          error_cnt = 0, n_checks = 0;
  css_row_t    rows [6];

  always #12.5 clk = ~clk;

  css_status css_status_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .acc(acc), .evt(evt),
    .ctrl(ctrl));
  css_core_model css_core_model_inst (.clk(clk), .acc(acc), .evt(evt));

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  function automatic css_ctrl_t exp_ctrl(css_row_t r);
    css_ctrl_t c;
    logic      usr;
    usr = ~r.st[1];
    c.cop_fault = r.a.cop_valid & ((r.a.cop_num == 2'd0) ?
                  usr & ~r.st[28] : ~r.st[28 + r.a.cop_num]);
    c.addr_fault = usr & r.a.data_valid & (r.a.data_addr > 32'h7fffffff);
    c.priv_fault = usr & r.a.priv_instr & ~r.st[28];
    c.irq_active = r.st[15:8] & r.pend;
    c.irq_take = r.st[0] & (|c.irq_active);
    c.big_endian = ~(usr & r.st[25]);
    c.boot_vectors = r.st[22];
    c.parity_zero = r.st[18];
    c.no_ext_bus = r.st[16];
    c.inval_store = r.st[16] & r.a.data_valid & r.a.data_partial;
    c.swap_caches = r.st[17];
    return c;
  endfunction : exp_ctrl

  initial begin
    #(25ns * 20000);
    error_cnt++;
    test_done();
  end

  initial begin
    rows[0] = '{32'h00000002, {1'b1, 2'd0, 1'b1, 32'h80000000, 2'b01}, 8'hff};
    rows[1] = '{32'h00000000, {1'b1, 2'd0, 1'b1, 32'h80000000, 2'b01}, 8'hff};
    rows[2] = '{32'h12000000, {1'b1, 2'd0, 1'b1, 32'h7fffffff, 2'b01}, 8'h00};
    rows[3] = '{32'h4000ff01, {1'b1, 2'd2, 1'b0, 32'h00000000, 2'b00}, 8'h81};
    rows[4] = '{32'h0007a502, {1'b1, 2'd1, 1'b1, 32'h00001000, 2'b10}, 8'hff};
    rows[5] = '{32'h20400003, {1'b1, 2'd1, 1'b0, 32'h00000000, 2'b00}, 8'h00};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0);
    chk("reset status", rd, 32'h00400002);
    chk("hresp", {31'h0, hresp}, 32'h0);
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b1, 32'h0, 32'hffffffff);
    ahb(1'b0, 32'h0, 32'h0);
    chk("fixed zero", rd, 32'hf247ff3f);
    ahb(1'b0, 32'h100, 32'h0);
    chk("unmapped", rd, 32'h0);
    // ---------------------------------------------------------------
    // Control table
    // ---------------------------------------------------------------
    foreach (rows[i]) begin
      ahb(1'b1, 32'h0, rows[i].st);
      css_core_model_inst.set_acc(rows[i].a, rows[i].pend);
      repeat (3) @(posedge clk);
      chk("ctrl", 32'(ctrl), 32'(exp_ctrl(rows[i])));
    end
    // ---------------------------------------------------------------
    // Mode stack push and pop
    // ---------------------------------------------------------------
    ahb(1'b1, 32'h0, 32'h34);
    css_core_model_inst.pulse('{take_exc: 1'b1, default: '0});
    ahb(1'b0, 32'h0, 32'h0);
    chk("push", rd, 32'h12);
    css_core_model_inst.pulse('{ret_exc: 1'b1, default: '0});
    ahb(1'b0, 32'h0, 32'h0);
    chk("pop", rd, 32'h14);
    // ---------------------------------------------------------------
    // Hardware flags
    // ---------------------------------------------------------------
    ahb(1'b1, 32'h0, 32'h0);
    css_core_model_inst.pulse('{dcache_miss: 1'b1, tlb_multi: 1'b1,
                                parity_err: 1'b1, default: '0});
    ahb(1'b1, 32'h0, 32'h0);
    ahb(1'b0, 32'h0, 32'h0);
    chk("flags", rd, 32'h00300000);
    ahb(1'b1, 32'h0, 32'h00010000);
    css_core_model_inst.pulse('{dcache_miss: 1'b1, default: '0});
    ahb(1'b0, 32'h0, 32'h0);
    chk("iso miss", rd, 32'h00390000);
    // Mid-run hardware reset clears the sticky flags
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h0, 32'h0);
    chk("rerun reset", rd, 32'h00400002);
    test_done();
  end
endmodule : tb
